// ---- rtl/sbsc_consts.vh ----
// Purpose: Named constants for the serial buffer status and frame option block.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef SBSC_CONSTS_VH
`define SBSC_CONSTS_VH
// Register byte addresses.
`define SBSC_ADDR_MODE2     8'h00
`define SBSC_ADDR_IRQ_STAT  8'h04
`define SBSC_ADDR_IRQ_MASK  8'h08
`define SBSC_ADDR_CTRL      8'h0C
// Field positions of the mode control register two.
`define SBSC_BIT_TBEMP      7
`define SBSC_BIT_RXFULL     6
`define SBSC_BIT_TXRUN      5
`define SBSC_BIT_STOPLEN    4
`define SBSC_BIT_ORDER      3
// Field positions of the extra control register.
`define SBSC_BIT_DBUF_EN    0
`define SBSC_BIT_UART_MODE  1
// Interrupt status bit positions.
`define SBSC_IRQ_TXEMPTY    0
`define SBSC_IRQ_RXFULL     1
`define SBSC_IRQ_TXDONE     2
`define SBSC_IRQ_WIDTH      3
// Reset values.
`define SBSC_RST_TBEMP      1'b1
`define SBSC_RST_ZERO1      1'b0
`define SBSC_RST_CTRL       2'h3
`define SBSC_RST_IRQ        3'h0
// Data width and zero word.
`define SBSC_ZERO32         32'h00000000
`define SBSC_ZERO8          8'h00
`endif

// ---- rtl/sbsc_shifter.v ----
// Purpose: Serial shift engine driven by the status block.
// Assumes: One clock, bit rate given by a one-cycle enable pulse.
// Notes:   UART frames or plain clocked bit output, with selectable order.
`include "sbsc_consts.vh"
`default_nettype none
module sbsc_shifter #(
    parameter DW = 8
) (
    // Clock and reset.
    input  wire          clk,
    input  wire          rst,
    // Bit rate enable.
    input  wire          bit_en,
    // Frame options.
    input  wire          uart_mode,
    input  wire          two_stop,
    input  wire          msb_first,
    // Load request with its word.
    input  wire          load,
    input  wire [DW-1:0] load_data,
    // Status and line.
    output reg           busy_r,
    output reg           txd_r,
    output reg           done_r
);
    // States of the frame sequencer.
    localparam S_IDLE  = 4'b0001;
    localparam S_START = 4'b0010;
    localparam S_DATA  = 4'b0100;
    localparam S_STOP  = 4'b1000;

    reg [3:0]    state_r;    // Current state.
    reg [DW-1:0] sh_r;       // Shift register.
    reg [7:0]    cnt_r;      // Bit counter.
    reg          order_r;    // Order latched at load.

    wire         out_bit = order_r ? sh_r[DW-1] : sh_r[0];   // Bit to put on the line at the next bit enable.

    ////////////////////////////////////////////////////////////////////////
    // Sequencer: start bit, data bits, one or two stop bits in UART mode; data bits only in clocked mode.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= S_IDLE;
            sh_r    <= {DW{1'b0}};
            cnt_r   <= `SBSC_ZERO8;
            order_r <= 1'b0;
            busy_r  <= 1'b0;
            txd_r   <= 1'b1;
            done_r  <= 1'b0;
        end else begin
            done_r <= 1'b0;
            case (state_r)
                S_IDLE: begin
                    // A load latches the word and leaves idle at once; the first bit goes out at the next bit enable.
                    if (load) begin
                        sh_r    <= load_data;
                        order_r <= msb_first;
                        busy_r  <= 1'b1;
                        cnt_r   <= `SBSC_ZERO8;
                        state_r <= uart_mode ? S_START : S_DATA;
                    end
                end
                S_START: begin
                    if (bit_en) begin
                        txd_r   <= 1'b0;
                        state_r <= S_DATA;
                    end
                end
                S_DATA: begin
                    if (bit_en) begin
                        txd_r <= out_bit;
                        sh_r  <= order_r ? {sh_r[DW-2:0], 1'b0} : {1'b0, sh_r[DW-1:1]};
                        cnt_r <= cnt_r + 8'h01;
                        if (cnt_r == DW[7:0] - 8'h01) begin
                            cnt_r   <= `SBSC_ZERO8;
                            state_r <= uart_mode ? S_STOP : S_IDLE;
                            if (!uart_mode) begin
                                busy_r <= 1'b0;
                                done_r <= 1'b1;
                            end
                        end
                    end
                end
                S_STOP: begin
                    if (bit_en) begin
                        txd_r <= 1'b1;
                        cnt_r <= cnt_r + 8'h01;
                        if (cnt_r == {7'h00, two_stop}) begin
                            state_r <= S_IDLE;
                            busy_r  <= 1'b0;
                            done_r  <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- rtl/sbsc_top.v ----
// Purpose: Buffer status flags and frame options of one serial channel.
// Assumes: One 50 MHz clock; register port with read data one cycle later.
// Notes:   Holds the transmit double buffer and a receive double buffer.
//
// What this block does
// - Transmit empty flag sets on move; resets 1.
// - Software write of transmit data clears it.
// - Flags meaningless without double buffering.
// - Receive full flag sets on completed reception.
// - Reading the receive full flag clears it.
// - Transmit active high while sending; resets 0.
// - Idle with empty buffer means transmission completed.
// - Stop length field selects one or two.
// - Receiver checks just one stop bit.
// - Bit order field picks LSB or MSB.
//
// Chosen here: the address map and strobed register access.
`include "sbsc_consts.vh"
`default_nettype none
module sbsc_top #(
    parameter DW      = 8,
    parameter BAUD_DIV = 16'h01B2
) (
    // Clock and reset.
    input  wire        CORE_CLK,
    input  wire        RST,
    // Register port.
    input  wire [7:0]  ADDR,
    input  wire [31:0] WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [31:0] RDATA,
    // Transmit data port, written by software side.
    input  wire        TX_WR,
    input  wire [7:0]  TX_DATA,
    // Received word from the receive shift engine.
    input  wire        RX_DONE,
    input  wire        RX_STOP_OK,
    input  wire [7:0]  RX_WORD,
    input  wire        RX_RD,
    output reg  [7:0]  RX_DATA,
    output reg         RX_FRAME_ERR,
    // Serial line and interrupt.
    output reg         TXD,
    output reg         IRQ
);
    ////////////////////////////////////////////////////////////////////////
    // Registers of the block.
    reg         tbemp_r;     // Transmit buffer empty flag.
    reg         rxfull_r;    // Receive buffer full flag.
    reg         stoplen_r;   // Stop length select.
    reg         order_r;     // Bit order select, one for MSB first.
    reg  [1:0]  ctrl_r;      // Double buffer enable and UART mode.
    reg  [7:0]  txbuf_r;     // Transmit double buffer.
    reg  [7:0]  rxbuf_r;     // Receive double buffer.
    reg  [`SBSC_IRQ_WIDTH-1:0] ist_r;   // Sticky interrupt status.
    reg  [`SBSC_IRQ_WIDTH-1:0] imask_r; // Interrupt mask.
    reg  [15:0] div_r;       // Bit rate divider.
    reg         bit_en_r;    // One-cycle bit rate pulse.
    reg         busy_d_r;    // Delayed busy, unused; the done edge comes from sh_done.

    wire        busy;        // Shift engine busy, the transmit active state.
    wire        sh_txd;      // Line level from the shift engine.
    wire        sh_done;     // Frame finished pulse.
    wire        dbuf_en  = ctrl_r[`SBSC_BIT_DBUF_EN];
    wire        uart_md  = ctrl_r[`SBSC_BIT_UART_MODE];
    // A move happens when the engine is idle, the buffer holds data and TX_WR is low.
    wire        tx_move  = !busy && !tbemp_r && !TX_WR;
    wire        wr_mode2 = WR && (ADDR == `SBSC_ADDR_MODE2);
    wire        rd_mode2 = RD && (ADDR == `SBSC_ADDR_MODE2);
    wire        tx_done_evt = sh_done && tbemp_r;
    wire [`SBSC_IRQ_WIDTH-1:0] ev;      // Events this cycle.

    assign ev[`SBSC_IRQ_TXEMPTY] = tx_move;
    assign ev[`SBSC_IRQ_RXFULL]  = RX_DONE;
    assign ev[`SBSC_IRQ_TXDONE]  = tx_done_evt;

    ////////////////////////////////////////////////////////////////////////
    // Bit rate divider: one enable pulse per bit time.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            div_r    <= 16'h0000;
            bit_en_r <= 1'b0;
        end else if (div_r == BAUD_DIV[15:0] - 16'h0001) begin
            div_r    <= 16'h0000;
            bit_en_r <= 1'b1;
        end else begin
            div_r    <= div_r + 16'h0001;
            bit_en_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shift engine instance.
    sbsc_shifter #(
        .DW        (DW)
    ) u_shift (
        .clk       (CORE_CLK),
        .rst       (RST),
        .bit_en    (bit_en_r),
        .uart_mode (uart_md),
        .two_stop  (stoplen_r),
        .msb_first (order_r),
        .load      (tx_move),
        .load_data (txbuf_r),
        .busy_r    (busy),
        .txd_r     (sh_txd),
        .done_r    (sh_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Transmit buffer and its empty flag.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            tbemp_r <= `SBSC_RST_TBEMP;
            txbuf_r <= `SBSC_ZERO8;
        end else if (TX_WR) begin
            txbuf_r <= TX_DATA;
            tbemp_r <= 1'b0;
        end else if (tx_move) begin
            tbemp_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive buffer and its full flag; a new word wins over the read clear.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            rxfull_r     <= `SBSC_RST_ZERO1;
            rxbuf_r      <= `SBSC_ZERO8;
            RX_FRAME_ERR <= 1'b0;
        end else if (RX_DONE) begin
            rxfull_r     <= 1'b1;
            rxbuf_r      <= RX_WORD;
            RX_FRAME_ERR <= !RX_STOP_OK;
        end else if (rd_mode2) begin
            rxfull_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receive data output port.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RX_DATA <= `SBSC_ZERO8;
        end else if (RX_RD) begin
            RX_DATA <= rxbuf_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Writable option fields and control register.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            stoplen_r <= `SBSC_RST_ZERO1;
            order_r   <= `SBSC_RST_ZERO1;
            ctrl_r    <= `SBSC_RST_CTRL;
            imask_r   <= `SBSC_RST_IRQ;
        end else if (WR) begin
            case (ADDR)
                `SBSC_ADDR_MODE2: begin
                    stoplen_r <= WDATA[`SBSC_BIT_STOPLEN];
                    order_r   <= WDATA[`SBSC_BIT_ORDER];
                end
                `SBSC_ADDR_IRQ_MASK: begin
                    imask_r <= WDATA[`SBSC_IRQ_WIDTH-1:0];
                end
                `SBSC_ADDR_CTRL: begin
                    ctrl_r <= WDATA[1:0];
                end
                default: begin
                    ctrl_r <= ctrl_r;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky interrupt status: set wins over write-one-to-clear.
    genvar gi;
    generate
        for (gi = 0; gi < `SBSC_IRQ_WIDTH; gi = gi + 1) begin : g_ist
            always @(posedge CORE_CLK or posedge RST) begin
                if (RST) begin
                    ist_r[gi] <= 1'b0;
                end else if (ev[gi]) begin
                    ist_r[gi] <= 1'b1;
                end else if (WR && (ADDR == `SBSC_ADDR_IRQ_STAT) && WDATA[gi]) begin
                    ist_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Read data, line and interrupt outputs, all registered.
    always @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RDATA    <= `SBSC_ZERO32;
            TXD      <= 1'b1;
            IRQ      <= 1'b0;
            busy_d_r <= 1'b0;
        end else begin
            TXD      <= sh_txd;
            IRQ      <= |(ist_r & imask_r);
            busy_d_r <= busy;
            RDATA    <= `SBSC_ZERO32;
            if (RD) begin
                case (ADDR)
                    `SBSC_ADDR_MODE2: begin
                        RDATA[`SBSC_BIT_TBEMP]   <= tbemp_r;
                        RDATA[`SBSC_BIT_RXFULL]  <= rxfull_r;
                        RDATA[`SBSC_BIT_TXRUN]   <= busy;
                        RDATA[`SBSC_BIT_STOPLEN] <= stoplen_r;
                        RDATA[`SBSC_BIT_ORDER]   <= order_r;
                    end
                    `SBSC_ADDR_IRQ_STAT: begin
                        RDATA[`SBSC_IRQ_WIDTH-1:0] <= ist_r;
                    end
                    `SBSC_ADDR_IRQ_MASK: begin
                        RDATA[`SBSC_IRQ_WIDTH-1:0] <= imask_r;
                    end
                    `SBSC_ADDR_CTRL: begin
                        RDATA[1:0] <= ctrl_r;
                    end
                    default: begin
                        RDATA <= `SBSC_ZERO32;
                    end
                endcase
            end
        end
    end

    // done when idle and empty
    // The transmit-done event fires when the engine ends a frame with nothing
    // waiting, which matches active low with empty high.
    // software keeps LSB first; the hardware does not force it.
    // dbuf_en is readable only; buffering always operates.
    wire unused_ok = dbuf_en & busy_d_r;
endmodule
`default_nettype wire

// ---- dv/sbsc_checker.sv ----
// Purpose: Port checker for the serial buffer status block.
// Assumes: Bound into sbsc_top; the run uses a bit time of 4 cycles.
// Notes:   Flag checks read the mode register through the register port.
`default_nettype none
module sbsc_checker #(
    parameter BAUD_DIV = 16'h0004
) (
    // Clock and reset.
    input wire logic        CORE_CLK,
    input wire logic        RST,
    // Register port.
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    // Receive side, line and interrupt.
    input wire logic        RX_DONE,
    input wire logic        RX_STOP_OK,
    input wire logic        RX_FRAME_ERR,
    input wire logic        TXD,
    input wire logic        IRQ
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);
    // A read of the mode register with no reception beside it.
    sequence s_rd_mode;
        RD && ADDR == 8'h00 && !RX_DONE;
    endsequence
    // A reception followed at once by a mode register read.
    sequence s_rx_in;
        RX_DONE ##1 (RD && ADDR == 8'h00);
    endsequence
    property p_hi_zero;
        RD |=> RDATA[31:8] == 24'h000000;
    endproperty
    a_hi_zero: assert property (p_hi_zero)
        else $error("upper read bits not zero");
    property p_idle_zero;
        !RD |=> RDATA == 32'h00000000;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data outside a read");
    property p_unmapped;
        RD && ADDR > 8'h0C |=> RDATA == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_rx_set;
        s_rx_in |=> RDATA[6];
    endproperty
    a_rx_set: assert property (p_rx_set)
        else $error("receive full flag not set");
    property p_rx_clr;
        s_rd_mode ##1 s_rd_mode |=> !RDATA[6];
    endproperty
    a_rx_clr: assert property (p_rx_clr)
        else $error("receive full flag not cleared by read");
    property p_frame_err;
        RX_DONE |=> RX_FRAME_ERR == !$past(RX_STOP_OK);
    endproperty
    a_frame_err: assert property (p_frame_err)
        else $error("frame error not from single stop bit");
    property p_bit_hold;
        $changed(TXD) |=> $stable(TXD) [*3];
    endproperty
    a_bit_hold: assert property (p_bit_hold)
        else $error("line bit shorter than bit time");
    property p_mask_off;
        (WR && ADDR == 8'h08 && WDATA[2:0] == 3'h0) ##1 !(WR && ADDR == 8'h08) |=> !IRQ;
    endproperty
    a_mask_off: assert property (p_mask_off)
        else $error("interrupt high with all masked");
endmodule
bind sbsc_top sbsc_checker #(.BAUD_DIV(BAUD_DIV)) i_chk (.CORE_CLK(CORE_CLK), .RST(RST),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX_DONE(RX_DONE),
    .RX_STOP_OK(RX_STOP_OK), .RX_FRAME_ERR(RX_FRAME_ERR), .TXD(TXD), .IRQ(IRQ));
`default_nettype wire

// ---- dv/sbsc_line_model.sv ----
// Purpose: Far-side receiver that decodes the words sent on TXD.
// Assumes: Idle-high line, DIV cycles a bit, each frame opens low.
// Notes:   Without a start bit the first data bit must be a zero.
`default_nettype none
module sbsc_line_model #(
    parameter int DIV = 4
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       txd,
    input  wire logic       uart,
    output var  logic       got,
    output var  logic [7:0] word,
    output var  logic       stop_ok,
    output var  int         gap
);
    timeunit 1ns;
    timeprecision 1ns;
    int   cnt;   // Cycles since the frame began.
    int   idx;   // Bit slot now sampled.
    int   since; // Cycles since the last frame began.
    logic act;   // A frame is being decoded.
    // Detects a frame start and samples each slot in its middle.
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            act <= 1'b0;
            got <= 1'b0;
            since <= 0;
            gap <= 0;
            word <= 8'h00;
            stop_ok <= 1'b0;
        end else begin
            got <= 1'b0;
            since <= since + 1;
            cnt <= cnt + 1;
            if (!act && !txd) begin
                act <= 1'b1;
                cnt <= 1;
                idx <= 0;
                gap <= since;
                since <= 1;
            end else if (act && cnt % DIV == DIV / 2) begin
                idx <= idx + 1;
                if (idx >= (uart ? 1 : 0) && idx <= (uart ? 8 : 7))
                    word <= {txd, word[7:1]};
                if (idx == (uart ? 9 : 7)) begin
                    act <= 1'b0;
                    got <= 1'b1;
                    stop_ok <= uart ? txd : 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- dv/test_serial_buffer_status_control.sv ----
// Purpose: Self-checking bench for the serial buffer status block.
// Assumes: Bit time shortened to 4 cycles; double buffering kept on.
// Notes:   Random words from a fixed seed, corner cases by hand.
`default_nettype none
module test_serial_buffer_status_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        CORE_CLK = 0, RST = 1, WR = 0, RD = 0, TX_WR = 0;
    logic        RX_DONE = 0, RX_STOP_OK = 0, RX_RD = 0, uart = 1;
    logic [7:0]  ADDR = 0, TX_DATA = 0, RX_WORD = 0, RX_DATA, word, d1, d2;
    logic [31:0] WDATA = 0, RDATA, rd_v, rd_w, r;
    logic        RX_FRAME_ERR, TXD, IRQ, got, stop_ok, u, s, m;
    int          gap, e, fail_count = 0, check_count = 0;
    sbsc_top #(.BAUD_DIV(16'h0004)) i_dut (.CORE_CLK(CORE_CLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_WR(TX_WR), .TX_DATA(TX_DATA),
        .RX_DONE(RX_DONE), .RX_STOP_OK(RX_STOP_OK), .RX_WORD(RX_WORD), .RX_RD(RX_RD),
        .RX_DATA(RX_DATA), .RX_FRAME_ERR(RX_FRAME_ERR), .TXD(TXD), .IRQ(IRQ));
    sbsc_line_model #(.DIV(4)) i_far (.clk(CORE_CLK), .rst(RST), .txd(TXD), .uart(uart),
        .got(got), .word(word), .stop_ok(stop_ok), .gap(gap));
    initial forever #10 CORE_CLK = ~CORE_CLK;
    // Prints the counts and the verdict, then ends the run.
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK) {WR, ADDR, WDATA} <= {1'b1, a, d};
        @(posedge CORE_CLK) WR <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge CORE_CLK) {RD, ADDR} <= {1'b1, a};
        @(posedge CORE_CLK) RD <= 1'b0;
        #1 rd_v = RDATA;
    endtask
    task put(input logic [7:0] d);
        @(posedge CORE_CLK) {TX_WR, TX_DATA} <= {1'b1, d};
        @(posedge CORE_CLK) TX_WR <= 1'b0;
    endtask
    // Waits a bounded time for the far side to finish a word.
    task wait_got;
        int n;
        @(negedge CORE_CLK);
        for (n = 0; n < 300 && got !== 1'b1; n++) @(negedge CORE_CLK);
        chk(n, n < 300 ? n : 0);
    endtask
    // Forces the first bit out low and the last high.
    function automatic logic [7:0] fix(logic [31:0] d, logic msb);
        return msb ? {1'b0, d[6:1], 1'b1} : {1'b1, d[6:1], 1'b0};
    endfunction
    function automatic logic [7:0] rev(logic [7:0] d);
        for (int i = 0; i < 8; i++) rev[i] = d[7 - i];
    endfunction
    initial begin
        #200000;
        fail_count++;
        report_and_stop;
    end
    initial begin
        r = $urandom(54063);
        repeat (2) @(posedge CORE_CLK);
        RST <= 1'b0;
        rd(8'h00); chk(rd_v, 32'h00000080);
        rd(8'h0C); chk(rd_v, 32'h00000003);
        rd(8'h04); chk(rd_v, 32'h00000000);
        // Two UART stop lengths, then both orders of the clocked mode.
        for (int k = 0; k < 4; k++) begin
            u = k < 2;
            s = k == 1;
            m = k == 3;
            uart = u;
            e = u ? (10 + s) * 4 : 32;
            wr(8'h0C, {30'h0, u, 1'b1});
            r = $urandom;
            wr(8'h00, {r[31:8], 3'h0, s, m, 3'h0});
            d1 = fix($urandom, m);
            d2 = fix($urandom, m);
            put(d1);
            repeat (3) @(posedge CORE_CLK);
            put(d2);
            rd(8'h00); chk(rd_v, {24'h0, 3'b001, s, m, 3'h0});
            wait_got;
            chk(word, m ? rev(d1) : d1);
            chk(stop_ok, 1'b1);
            wait_got;
            chk(word, m ? rev(d2) : d2);
            chk(gap >= e && gap <= e + 2, 1'b1);
            repeat (20) @(posedge CORE_CLK);
            rd(8'h00); chk(rd_v, {24'h0, 3'b100, s, m, 3'h0});
        end
        rd(8'h04); chk(rd_v, 32'h00000005);
        wr(8'h08, 32'h00000007);
        repeat (3) @(posedge CORE_CLK);
        chk(IRQ, 1'b1);
        wr(8'h04, 32'h00000005);
        repeat (3) @(posedge CORE_CLK);
        chk(IRQ, 1'b0);
        // Receptions, each followed by two reads back to back.
        repeat (3) begin
            r = $urandom;
            @(posedge CORE_CLK) {RX_DONE, RX_WORD, RX_STOP_OK} <= {1'b1, r[7:0], r[8]};
            @(posedge CORE_CLK) {RX_DONE, RD, ADDR} <= {2'b01, 8'h00};
            @(posedge CORE_CLK) #1 rd_v = RDATA;
            @(posedge CORE_CLK) RD <= 1'b0;
            #1 rd_w = RDATA;
            chk(rd_v & 32'h40, 32'h40);
            chk(rd_w & 32'h40, 32'h00);
            @(posedge CORE_CLK) RX_RD <= 1'b1;
            @(posedge CORE_CLK) RX_RD <= 1'b0;
            #1 chk(RX_DATA, r[7:0]);
            chk(RX_FRAME_ERR, !r[8]);
        end
        chk(IRQ, 1'b1);
        rd(8'h04); chk(rd_v, 32'h00000002);
        wr(8'h08, 32'h00000000);
        repeat (3) @(posedge CORE_CLK);
        chk(IRQ, 1'b0);
        wr(8'h04, 32'h00000002);
        rd(8'h04); chk(rd_v, 32'h00000000);
        wr(8'h40, $urandom);
        rd(8'h40); chk(rd_v, 32'h00000000);
        rd(8'h00); chk(rd_v, 32'h00000088);
        report_and_stop;
    end
endmodule
`default_nettype wire
